// ---- rtl/fml_block.sv ----
/*
 * Interrupt masks, system event latch and interrupt pin driver.
 * Assumes the control port decoder delivers one-cycle read and write
 * strobes on mclk, the option bits come from a neighbouring register
 * on mclk, and the live event levels arrive from analog monitors.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fml_params.svh"

// Overview of operation
// - channel mask bits 7..4, reset zero
// - type mask bits 7,6 open and pair-short
// - type mask bits 5,4 short to ground
// - type mask bits 3,2 short to bias
// - type mask bits 1,0 battery; resets 0x00
// - latch bit 7 on audio-bus clock error
// - latch bit 6 on lock detected
// - latch bit 5 on over-temperature
// - latch bit 4 over-current; bits 3..0 zero
// - latch register read-only, resets to zero
// - system mask bits 7..4, reset masked
// - clear-on-read policy follows option bit
// - readback shows all or unmasked causes
// - interrupt level or 2 ms pulses, polarity
module fml_block #(
    parameter int PULSE_CYC = `FML_IRQ_PULSE_US * `FML_CLK_MHZ,
    parameter int PERIOD_CYC = `FML_IRQ_PERIOD_US * `FML_CLK_MHZ
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [3:0] sys_event_live,
    input wire logic [3:0] ch_fault_latched,
    input wire logic [7:0] fault_type_latched,
    input wire logic clear_on_read_option,
    input wire logic latch_readback_option,
    input wire logic irq_polarity,
    input wire logic [1:0] irq_event_mode,
    output logic irq_pin
);
    import fml_pkg::*;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    // =================================================================
    // register access decode
    logic [7:0] sys_mask_r;
    logic [7:0] ch_mask_r;
    logic [7:0] type_mask_r;
    logic [3:0] latch_r;
    logic [3:0] latch_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [3:0] latch_view;

    wire wr_sys_mask = reg_wr && (reg_addr == `FML_OFS_SYS_MASK);
    wire wr_ch_mask = reg_wr && (reg_addr == `FML_OFS_CH_MASK);
    wire wr_type_mask = reg_wr && (reg_addr == `FML_OFS_TYPE_MASK);
    wire rd_latch = reg_rd && (reg_addr == `FML_OFS_SYS_LATCH);

    // mask registers: 1 masks, 0 unmasks
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            sys_mask_r <= `FML_RST_SYS_MASK;
            ch_mask_r <= `FML_RST_CH_MASK;
            type_mask_r <= `FML_RST_TYPE_MASK;
        end
        else
        begin
            if (wr_sys_mask)
                sys_mask_r <= reg_wdata;
            if (wr_ch_mask)
                ch_mask_r <= reg_wdata;
            if (wr_type_mask)
                type_mask_r <= reg_wdata;
        end
    end

    // readback: all causes or unmasked only; low nibble reads zero
    assign latch_view = latch_readback_option ?
        (latch_r & ~sys_mask_r[`FML_EVT_MSB:`FML_EVT_LSB]) : latch_r;
    always_comb
    begin
        rdata_nxt = rdata_r;
        if (reg_rd)
        begin
            unique case (reg_addr)
                `FML_OFS_SYS_MASK: rdata_nxt = sys_mask_r;
                `FML_OFS_CH_MASK: rdata_nxt = ch_mask_r;
                `FML_OFS_TYPE_MASK: rdata_nxt = type_mask_r;
                `FML_OFS_SYS_LATCH: rdata_nxt = {latch_view, 4'h0};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    // read data holds until the next read
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            rdata_r <= 8'h00;
        else
            rdata_r <= rdata_nxt;
    end
    assign reg_rdata = rdata_r;

    // =================================================================
    // live event synchronisers and edge detect
    // bit 3 clock error, 2 lock, 1 over-temperature, 0 over-current
    logic [3:0] live_meta_r;
    logic [3:0] live_r;
    logic [3:0] live_prev_r;
    logic [3:0] rise;
    logic [3:0] clr;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            live_meta_r <= 4'h0;
            live_r <= 4'h0;
            live_prev_r <= 4'h0;
        end
        else
        begin
            live_meta_r <= sys_event_live;
            live_r <= live_meta_r;
            live_prev_r <= live_r;
        end
    end

    // =================================================================
    // latch: set on rising edge, set wins over read clear
    assign rise = live_r & ~live_prev_r;
    assign clr = !rd_latch ? 4'h0 :
        (clear_on_read_option ? 4'hF : ~live_r);
    assign latch_nxt = (latch_r & ~clr) | rise;

    // latch is only touched by events and reads, never by writes
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            latch_r <= `FML_RST_SYS_LATCH;
        else
            latch_r <= latch_nxt;
    end

    // =================================================================
    // interrupt source: any unmasked latched cause
    wire sys_pend = |(latch_r & ~sys_mask_r[`FML_EVT_MSB:`FML_EVT_LSB]);
    wire ch_pend = |(ch_fault_latched & ~ch_mask_r[`FML_EVT_MSB:`FML_EVT_LSB]);
    wire type_pend = |(fault_type_latched & ~type_mask_r);
    wire any_pend = sys_pend || ch_pend || type_pend;

    // =================================================================
    // interrupt pulse generator
    fml_irq_state_type state_r;
    fml_irq_state_type state_nxt;
    logic [16:0] cnt_r;
    logic [16:0] cnt_nxt;
    logic pend_prev_r;
    logic active;
    logic irq_r;

    wire mode_rep = (irq_event_mode == `FML_MODE_REPEAT);
    wire mode_one = (irq_event_mode == `FML_MODE_SINGLE);
    wire pend_rise = any_pend && !pend_prev_r;
    wire hi_done = (cnt_r == 17'(PULSE_CYC - 1));
    wire lo_done = (cnt_r == 17'(PERIOD_CYC - PULSE_CYC - 1));

    // state walk for repeating and single pulses
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r + 17'h00001;
        unique case (state_r)
            FML_IDLE:
            begin
                cnt_nxt = 17'h00000;
                if ((mode_rep && any_pend) || (mode_one && pend_rise))
                    state_nxt = FML_HIGH;
            end
            FML_HIGH:
            begin
                if (hi_done)
                begin
                    cnt_nxt = 17'h00000;
                    state_nxt = mode_rep ? FML_LOW : FML_IDLE;
                end
            end
            FML_LOW:
            begin
                if (lo_done || !mode_rep)
                begin
                    cnt_nxt = 17'h00000;
                    state_nxt = (mode_rep && any_pend) ? FML_HIGH : FML_IDLE;
                end
            end
        endcase
    end

    // level mode follows the source, pulse modes follow the state
    assign active = (mode_rep || mode_one) ? (state_nxt == FML_HIGH) : any_pend;

    // state, counter and pin, pin idles high for active-low default
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r <= FML_IDLE;
            cnt_r <= 17'h00000;
            pend_prev_r <= 1'b0;
            irq_r <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            pend_prev_r <= any_pend;
            irq_r <= irq_polarity ? active : !active;
        end
    end
    assign irq_pin = irq_r;

    // =================================================================
    // assertions
    property p_ch_mask_wr;
        wr_ch_mask |=> ch_mask_r == $past(reg_wdata);
    endproperty
    a_ch_mask_wr: assert property (p_ch_mask_wr) else $error("channel mask not stored");

    property p_type_mask_wr;
        wr_type_mask |=> type_mask_r[7:4] == $past(reg_wdata[7:4])
            && type_mask_r[3:0] == $past(reg_wdata[3:0]);
    endproperty
    a_type_mask_wr: assert property (p_type_mask_wr) else $error("type mask not stored");

    property p_sys_mask_wr;
        wr_sys_mask |=> sys_mask_r == $past(reg_wdata);
    endproperty
    a_sys_mask_wr: assert property (p_sys_mask_wr) else $error("system mask not stored");

    property p_clk_err_set;
        $rose(sys_event_live[3]) ##1 sys_event_live[3] |-> ##2 latch_r[3];
    endproperty
    a_clk_err_set: assert property (p_clk_err_set) else $error("clock error not latched");

    property p_hold;
        (!rd_latch && rise == 4'h0) |=> latch_r == $past(latch_r);
    endproperty
    a_hold: assert property (p_hold) else $error("latch changed without cause");

    property p_no_write;
        (reg_wr && reg_addr == `FML_OFS_SYS_LATCH && rise == 4'h0 && !rd_latch)
            |=> latch_r == $past(latch_r);
    endproperty
    a_no_write: assert property (p_no_write) else $error("latch written");

    property p_cor;
        (rd_latch && clear_on_read_option && rise == 4'h0) |=> latch_r == 4'h0;
    endproperty
    a_cor: assert property (p_cor) else $error("clear on read failed");

    property p_readback;
        rd_latch |=> reg_rdata == {$past(latch_view), 4'h0}
            && reg_rdata[3:0] == 4'h0;
    endproperty
    a_readback: assert property (p_readback) else $error("latch readback wrong");

    property p_level_irq;
        (irq_event_mode == `FML_MODE_LEVEL && !irq_polarity)
            |=> irq_pin == !$past(any_pend);
    endproperty
    a_level_irq: assert property (p_level_irq) else $error("level interrupt wrong");

    c_latch_read: cover property (rd_latch && latch_r != 4'h0);
    c_pulse: cover property (state_r == FML_HIGH ##1 state_r == FML_LOW);
    c_single: cover property (mode_one && pend_rise);
endmodule
`default_nettype wire

// ---- rtl/fml_params.svh ----
/*
 * Register offsets, reset values and timing figures for the fault
 * interrupt mask and latch block.
 * Assumes inclusion by bare name from the block and the bench.
 */
`ifndef FML_PARAMS_SVH
`define FML_PARAMS_SVH

// =====================================================================
// register offsets
`define FML_OFS_SYS_MASK 8'h29
`define FML_OFS_CH_MASK 8'h2A
`define FML_OFS_TYPE_MASK 8'h2B
`define FML_OFS_SYS_LATCH 8'h2C

// =====================================================================
// reset values
`define FML_RST_SYS_MASK 8'hFF
`define FML_RST_CH_MASK 8'h03
`define FML_RST_TYPE_MASK 8'h00
`define FML_RST_SYS_LATCH 4'h0

// =====================================================================
// field positions: event causes sit in bits 7..4 of their registers
`define FML_EVT_MSB 7
`define FML_EVT_LSB 4

// =====================================================================
// timing: pulse width and repeat period in microseconds, clock in MHz
`define FML_CLK_MHZ 25
`define FML_IRQ_PULSE_US 2000
`define FML_IRQ_PERIOD_US 4000

// =====================================================================
// interrupt event modes
`define FML_MODE_LEVEL 2'h0
`define FML_MODE_REPEAT 2'h2
`define FML_MODE_SINGLE 2'h3

`endif

// ---- rtl/fml_pkg.sv ----
/*
 * Types of the fault interrupt mask and latch block.
 * Assumes nothing of its surroundings.
 */
package fml_pkg;

    // =================================================================
    // interrupt pulse generator states, one-hot
    typedef enum logic [2:0] {
        FML_IDLE = 3'h1,
        FML_HIGH = 3'h2,
        FML_LOW = 3'h4
    } fml_irq_state_type;

endpackage

// ---- testbench/fml_host.sv ----
/*
 * Host controller model driving the register strobes of the block.
 * Assumes tasks are called from one process after a clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// host register port model
module fml_host (
    input wire logic mclk,
    output var logic [7:0] reg_addr,
    output var logic reg_wr,
    output var logic reg_rd,
    output var logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    // idle bus at time zero
    initial
    begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end

    // one write strobe, then released lines show inverted values
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1;
        reg_addr = a;
        reg_wdata = (a == 8'h2A) ? {d[7:4], 4'h3} : d;
        reg_wr = 1'b1;
        @(posedge mclk);
        #1;
        reg_wr = 1'b0;
        reg_wdata = ~reg_wdata;
        reg_addr = ~reg_addr;
    endtask

    // one read strobe, data taken one edge later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge mclk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~reg_addr;
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// ---- testbench/fml_block_test.sv ----
/*
 * Self-checking bench of the mask and latch block with a register model.
 * Assumes the host model and the params header on the include path.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fml_params.svh"

// =====================================================================
// bench top
module fml_block_test;
    localparam int PU = 4;
    localparam int PE = 8;
    localparam int W = 16;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    wire logic [7:0] reg_addr;
    wire logic reg_wr;
    wire logic reg_rd;
    wire logic [7:0] reg_wdata;
    wire logic [7:0] reg_rdata;
    wire logic irq_pin;
    logic [3:0] sys_event_live = 4'h0;
    logic [3:0] ch_fault_latched = 4'h0;
    logic [7:0] fault_type_latched = 8'h00;
    logic clear_on_read_option = 1'b0;
    logic latch_readback_option = 1'b0;
    logic irq_polarity = 1'b0;
    logic [1:0] irq_event_mode = 2'h0;
    logic [31:0] seed = 32'h9a6c;
    logic [31:0] r;
    logic [7:0] mreg [0:3] = '{`FML_RST_SYS_MASK, `FML_RST_CH_MASK, `FML_RST_TYPE_MASK, 8'h00};
    logic [3:0] mlat = 4'h0;
    int n_errors = 0;
    int n_compared = 0;
    int cyc = 0;

    fml_host host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    fml_block #(.PULSE_CYC(PU), .PERIOD_CYC(PE)) uut (.mclk(mclk), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .sys_event_live(sys_event_live),
        .ch_fault_latched(ch_fault_latched), .fault_type_latched(fault_type_latched),
        .clear_on_read_option(clear_on_read_option),
        .latch_readback_option(latch_readback_option), .irq_polarity(irq_polarity),
        .irq_event_mode(irq_event_mode), .irq_pin(irq_pin));

    // clock and hang guard
    always #20 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            n_errors++;
            test_done();
        end
    end

    // =================================================================
    // checking and model tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("errors=%0d compared=%0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic wrm(input logic [7:0] a, input logic [7:0] d);
        host.wr(a, d);
        if (a >= `FML_OFS_SYS_MASK && a < `FML_OFS_SYS_LATCH)
            mreg[a - 8'h29] = (a == 8'h2A) ? {d[7:4], 4'h3} : d;
    endtask

    // read and compare; latch model clears per policy after the read
    task automatic rdc(input logic [7:0] a);
        logic [7:0] d;
        logic [7:0] e;
        host.rd(a, d);
        e = 8'h00;
        if (a >= `FML_OFS_SYS_MASK && a < `FML_OFS_SYS_LATCH)
            e = mreg[a - 8'h29];
        if (a == `FML_OFS_SYS_LATCH)
        begin
            e = {latch_readback_option ? mlat & ~mreg[0][7:4] : mlat, 4'h0};
            mlat = clear_on_read_option ? 4'h0 : mlat & sys_event_live;
        end
        chk(d, e);
    endtask

    task automatic ev(input logic [3:0] v);
        mlat = mlat | (v & ~sys_event_live);
        sys_event_live = v;
        repeat (5) @(posedge mclk);
        #1;
    endtask

    // count active pin cycles over a window after a cause appears
    task automatic irq(input logic [1:0] m, input logic [3:0] c, input logic [7:0] t,
        input int e);
        int n = 0;
        logic [31:0] p;
        // own draw, so the caller's r still names the unmasked bit
        p = $random(seed);
        irq_polarity = p[0];
        irq_event_mode = m;
        repeat (12) @(posedge mclk);
        #1;
        ch_fault_latched = c;
        fault_type_latched = t;
        repeat (W)
        begin
            @(posedge mclk);
            #1;
            n += int'(irq_pin === irq_polarity);
        end
        chk(8'(n), 8'(e));
        ch_fault_latched = 4'h0;
        fault_type_latched = 8'h00;
    endtask

    // =================================================================
    // main sequence
    initial
    begin
        repeat (5) @(posedge mclk);
        #1;
        rstn = 1'b1;
        for (int a = 8'h29; a <= 8'h2C; a++)
            rdc(8'(a));
        irq(2'h0, 4'h8, 8'h00, W);
        irq(2'h1, 4'h8, 8'h00, W);
        irq(2'h2, 4'h8, 8'h00, W / PE * PU);
        irq(2'h3, 4'h8, 8'h00, PU);
        wrm(8'h2A, 8'hF3);
        irq(2'h0, 4'hF, 8'h00, 0);
        r = $random(seed);
        wrm(8'h2B, ~(8'h01 << r[2:0]));
        irq(2'h0, 4'h0, 8'h01 << r[2:0], W);
        irq(2'h0, 4'h0, ~(8'h01 << r[2:0]), 0);
        for (int i = 0; i < 3; i++)
        begin
            wrm(8'(8'h29 + i), $random(seed));
            rdc(8'(8'h29 + i));
        end
        wrm(8'h2C, 8'hFF);
        rdc(8'h2C);
        rdc(8'h30);
        for (int i = 0; i < 8; i++)
        begin
            clear_on_read_option = i[0];
            ev(4'h1 << (i >> 1));
            rdc(8'h2C);
            rdc(8'h2C);
            ev(4'h0);
            rdc(8'h2C);
        end
        // mid-run reset with a latched cause pending
        ev(4'h4);
        ev(4'h0);
        rstn = 1'b0;
        @(posedge mclk);
        #1;
        chk({7'h00, irq_pin}, 8'h01);
        chk(reg_rdata, 8'h00);
        rstn = 1'b1;
        mreg = '{`FML_RST_SYS_MASK, `FML_RST_CH_MASK, `FML_RST_TYPE_MASK, 8'h00};
        mlat = 4'h0;
        for (int a = 8'h29; a <= 8'h2C; a++)
            rdc(8'(a));
        latch_readback_option = 1'b1;
        wrm(8'h29, $random(seed));
        ev(4'hF);
        rdc(8'h2C);
        test_done();
    end
endmodule
`default_nettype wire
